// ---- hdl/doalu_pkg.sv ----
// Package with the operation codes, widths and flag positions of the double-operand datapath.
package doalu_pkg;
    localparam int DOALU_WORD_W = 16;
    localparam int DOALU_BYTE_W = 8;
    localparam int DOALU_CNT_W = 6;
    localparam logic [3:0] DOALU_FLAGS_RST = 4'h0;
    localparam int DOALU_FLAG_N = 3;
    localparam int DOALU_FLAG_Z = 2;
    localparam int DOALU_FLAG_V = 1;
    localparam int DOALU_FLAG_C = 0;

    // Operation select presented with each request.
    typedef enum logic [2:0] {
        DOALU_WORD_COPY_OP,
        DOALU_BYTE_COPY_OP,
        DOALU_COMPARE_OP,
        DOALU_BYTE_COMPARE_OP,
        DOALU_ADD_OP,
        DOALU_SUB_OP,
        DOALU_ARITH_SHIFT_OP
    } doalu_op_t;
endpackage

// ---- hdl/doalu_shifter.sv ----
// Arithmetic shifter with sign-change and last-bit-out detection.
`timescale 1ns/1ps
`default_nettype none
module doalu_shifter #(
    parameter int WIDTH = 16,
    parameter int CNT_W = 6
) (
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [CNT_W-1:0] count_i,
    output logic [WIDTH-1:0] result_o,
    output logic sign_changed_o,
    output logic carry_o
);
    // Walking one bit per step mirrors the sequential shift, so every intermediate sign is seen.
    always_comb begin
        logic [WIDTH-1:0] acc;
        logic signed [CNT_W-1:0] cnt;
        int steps;
        acc = value_i;
        cnt = signed'(count_i);
        steps = 0;
        sign_changed_o = 1'b0;
        carry_o = 1'b0;
        if (cnt < 0) begin
            steps = -int'(cnt);
        end else begin
            steps = int'(cnt);
        end
        // The bound is inclusive: a count of -32 must really shift 32 places to the right.
        for (int i = 0; i <= (1 << (CNT_W - 1)); i++) begin
            if (i < steps) begin
                if (cnt < 0) begin
                    carry_o = acc[0];
                    acc = {acc[WIDTH-1], acc[WIDTH-1:1]};
                end else begin
                    carry_o = acc[WIDTH-1];
                    acc = {acc[WIDTH-2:0], 1'b0};
                    if (acc[WIDTH-1] != value_i[WIDTH-1]) begin
                        sign_changed_o = 1'b1;
                    end
                end
            end
        end
        result_o = acc;
    end
endmodule
`default_nettype wire

// ---- hdl/doalu_top.sv ----
// Double-operand ALU datapath: copy, compare, add, subtract and arithmetic shift.
// Overview of operation
// - compare writes nothing, only updates flags.
// - compare computes source minus destination.
// - N and Z follow result sign and zero.
// - compare overflow: signs differ, destination matches result.
// - compare/subtract carry is inverted carry-out, borrow.
// - add stores sum, overflow on like-sign flip.
// - subtract stores destination minus source.
// - subtract overflow: signs differ, source matches result.
// - add and subtract are word only.
// - byte copy acts like word copy on bytes.
// - shift count is source low six bits.
// - signed count, negative right, positive left.
// - shift overflow when sign bit ever changes.
// - shift carry holds last bit out.
`timescale 1ns/1ps
`default_nettype none
module doalu_top #(
    parameter int WIDTH = doalu_pkg::DOALU_WORD_W
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire doalu_pkg::doalu_op_t op_i,
    input wire logic dst_is_reg_i,
    input wire logic [WIDTH-1:0] src_i,
    input wire logic [WIDTH-1:0] dst_i,
    output logic done_o,
    output logic write_o,
    output logic byte_write_o,
    output logic [WIDTH-1:0] result_o,
    output logic [3:0] flags_o
);
    import doalu_pkg::*;

    // A request is taken at the rising edge at which start_i is high, and its outcome shows
    // on the outputs one cycle later. The write strobes stand for that single cycle, while
    // result_o and flags_o hold until the next request, so the caller may read them late.
    // Operands must stand together with start_i; nothing is captured ahead of that edge.
    // Everything between the operand ports and the output flops is combinational: the whole
    // operation, a 32-place shift included, has to settle within one core clock period.
    // Requests may follow each other in every cycle; there is no busy state to wait for.
    // Add and subtract have no byte form; the instruction decoding in front of this block
    // has no code to send for one, so none can arrive.

    // Byte operations use the low byte of the source; byte compare also uses the low byte of the destination.
    localparam int BW = DOALU_BYTE_W;

    // The flag vector is {N, Z, V, C} with N at the top. The package names each position,
    // so no bit index of the flags is spelled out twice, and each flag is written only by
    // the operations that define it; every other flag keeps its value.

    // Separate word adders for add, subtract and compare; one extra bit captures the carry.
    // Subtraction adds the inverted operand plus one, so the top bit of each difference is a
    // carry and not a borrow; the flag logic inverts it where the flags report a borrow.
    wire logic [WIDTH:0] add_sum;
    wire logic [WIDTH:0] sub_diff;
    wire logic [WIDTH:0] compare_diff;
    wire logic [BW:0] byte_compare_diff;
    assign add_sum = {1'b0, src_i} + {1'b0, dst_i};
    assign sub_diff = {1'b0, dst_i} + {1'b0, ~src_i} + {{WIDTH{1'b0}}, 1'b1};
    assign compare_diff = {1'b0, src_i} + {1'b0, ~dst_i} + {{WIDTH{1'b0}}, 1'b1};
    assign byte_compare_diff = {1'b0, src_i[BW-1:0]} + {1'b0, ~dst_i[BW-1:0]} + {{BW{1'b0}}, 1'b1};

    // Sign bits used by the overflow equations.
    // Overflow needs only the operand signs and the result sign: a sum of two like-signed
    // operands cannot overflow unless its sign differs from theirs, and a difference
    // overflows only when the operands differ in sign.
    wire logic s_sgn;
    wire logic d_sgn;
    wire logic sb_sgn;
    wire logic db_sgn;
    assign s_sgn = src_i[WIDTH-1];
    assign d_sgn = dst_i[WIDTH-1];
    assign sb_sgn = src_i[BW-1];
    assign db_sgn = dst_i[BW-1];

    // Shifter works on the destination register with the source's low count bits.
    // Only the destination is shifted; the source supplies nothing but the count.
    // The upper source bits are ignored, so a source of 64 acts as no shift at all.
    // The shifter is a long combinational chain; pipelining it would cost every operation
    // a cycle, which weighs more than the slower path at this clock rate.
    wire logic [WIDTH-1:0] sh_res;
    wire logic sh_v;
    wire logic sh_c;
    doalu_shifter #(
        .WIDTH(WIDTH),
        .CNT_W(DOALU_CNT_W)
    ) u_shifter (
        .value_i(dst_i),
        .count_i(src_i[DOALU_CNT_W-1:0]),
        .result_o(sh_res),
        .sign_changed_o(sh_v),
        .carry_o(sh_c)
    );

    // Byte copy value: a register destination gets the byte's sign through the upper byte,
    // so the whole register reads as the same signed number as the byte.
    // A memory destination takes only the low byte, so byte_write_o tells the outside logic
    // to write that byte alone; the zero upper byte is then of no consequence.
    wire logic [WIDTH-1:0] byte_copy_val;
    assign byte_copy_val = dst_is_reg_i ? {{(WIDTH-BW){sb_sgn}}, src_i[BW-1:0]}
                                        : {{(WIDTH-BW){1'b0}}, src_i[BW-1:0]};

    // Next result, write qualifiers and flags; byte compare flags come from the low byte.
    // The case below is the only place where an operation code is decoded, so a new code
    // needs one new branch here and nothing else.
    // Flags not named in a branch keep their present value.
    logic [WIDTH-1:0] next_result;
    logic next_write;
    logic next_byte;
    logic [3:0] next_flags;
    always_comb begin
        // Defaults: no write, flags held and the destination passed through unchanged.
        // The default result is harmless, as no write strobe goes with it.
        next_result = dst_i;
        next_write = 1'b0;
        next_byte = 1'b0;
        next_flags = flags_o;
        case (op_i)
            // Word copy: the source goes to the destination; the carry is left as it was.
            DOALU_WORD_COPY_OP: begin
                next_result = src_i;
                next_write = 1'b1;
                next_flags[DOALU_FLAG_N] = src_i[WIDTH-1];
                next_flags[DOALU_FLAG_Z] = (src_i == '0);
                next_flags[DOALU_FLAG_V] = 1'b0;
            end

            // Byte copy: as word copy, with the flags taken from the low byte only.
            DOALU_BYTE_COPY_OP: begin
                next_result = byte_copy_val;
                next_write = 1'b1;
                next_byte = ~dst_is_reg_i;
                next_flags[DOALU_FLAG_N] = sb_sgn;
                next_flags[DOALU_FLAG_Z] = (src_i[BW-1:0] == '0);
                next_flags[DOALU_FLAG_V] = 1'b0;
            end

            // Compare: source minus destination, the reverse of the subtract order.
            DOALU_COMPARE_OP: begin
                // No write: destination and source stay as they were.
                next_write = 1'b0;
                next_flags[DOALU_FLAG_N] = compare_diff[WIDTH-1];
                next_flags[DOALU_FLAG_Z] = (compare_diff[WIDTH-1:0] == '0);
                next_flags[DOALU_FLAG_V] = (s_sgn != d_sgn) && (d_sgn == compare_diff[WIDTH-1]);
                next_flags[DOALU_FLAG_C] = ~compare_diff[WIDTH];
            end

            // Byte compare: the same equations on the low byte; the upper bytes play no part.
            DOALU_BYTE_COMPARE_OP: begin
                next_write = 1'b0;
                next_flags[DOALU_FLAG_N] = byte_compare_diff[BW-1];
                next_flags[DOALU_FLAG_Z] = (byte_compare_diff[BW-1:0] == '0);
                next_flags[DOALU_FLAG_V] = (sb_sgn != db_sgn) && (db_sgn == byte_compare_diff[BW-1]);
                next_flags[DOALU_FLAG_C] = ~byte_compare_diff[BW];
            end

            // Add: the sum goes to the destination and a carry out of the top bit sets C.
            DOALU_ADD_OP: begin
                // Word only; there is deliberately no byte add.
                next_result = add_sum[WIDTH-1:0];
                next_write = 1'b1;
                next_flags[DOALU_FLAG_N] = add_sum[WIDTH-1];
                next_flags[DOALU_FLAG_Z] = (add_sum[WIDTH-1:0] == '0);
                next_flags[DOALU_FLAG_V] = (s_sgn == d_sgn) && (add_sum[WIDTH-1] != s_sgn);
                next_flags[DOALU_FLAG_C] = add_sum[WIDTH];
            end

            // Subtract: destination minus source; a set C reports a borrow.
            DOALU_SUB_OP: begin
                next_result = sub_diff[WIDTH-1:0];
                next_write = 1'b1;
                next_flags[DOALU_FLAG_N] = sub_diff[WIDTH-1];
                next_flags[DOALU_FLAG_Z] = (sub_diff[WIDTH-1:0] == '0);
                next_flags[DOALU_FLAG_V] = (s_sgn != d_sgn) && (s_sgn == sub_diff[WIDTH-1]);
                next_flags[DOALU_FLAG_C] = ~sub_diff[WIDTH];
            end

            // Arithmetic shift of the destination register; N and Z follow the shifted value.
            DOALU_ARITH_SHIFT_OP: begin
                next_result = sh_res;
                next_write = 1'b1;
                next_flags[DOALU_FLAG_N] = sh_res[WIDTH-1];
                next_flags[DOALU_FLAG_Z] = (sh_res == '0);
                next_flags[DOALU_FLAG_V] = sh_v;
                next_flags[DOALU_FLAG_C] = sh_c;
            end

            // Unused codes write nothing and leave the flags alone.
            default: begin
                next_write = 1'b0;
            end
        endcase
    end

    // Results register one cycle after the request; flags hold between requests.
    // Result and flags load only with a request, so an idle cycle leaves them readable; the
    // strobes are rewritten every cycle, so none can stand for two.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // Reset clears every output, the flags included.
            done_o <= 1'b0;
            write_o <= 1'b0;
            byte_write_o <= 1'b0;
            result_o <= '0;
            flags_o <= DOALU_FLAGS_RST;
        end else begin
            // A request in this cycle becomes the strobes of the next.
            done_o <= start_i;
            write_o <= start_i & next_write;
            byte_write_o <= start_i & next_write & next_byte;
            // Every output comes straight from a flop, so none glitches while operands settle.
            if (start_i) begin
                result_o <= next_result;
                flags_o <= next_flags;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/doalu_props.sv ----
// Checker of the double-operand datapath outputs.
`timescale 1ns/1ps
`default_nettype none
module doalu_props #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire doalu_pkg::doalu_op_t op_i,
    input wire logic dst_is_reg_i,
    input wire logic [WIDTH-1:0] src_i,
    input wire logic [WIDTH-1:0] dst_i,
    input wire logic done_o,
    input wire logic write_o,
    input wire logic byte_write_o,
    input wire logic [WIDTH-1:0] result_o,
    input wire logic [3:0] flags_o
);
    import doalu_pkg::*;
    localparam int M = WIDTH - 1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Flags of a minus b; C is a borrow, the inverse of the adder carry.
    function automatic logic [3:0] fs(logic [M:0] a, logic [M:0] b);
        logic [M:0] r;
        r = a - b;
        return {r[M], r == '0, a[M] != b[M] && b[M] == r[M], a < b};
    endfunction
    // Flags of a plus b.
    function automatic logic [3:0] fa(logic [M:0] a, logic [M:0] b);
        logic [M+1:0] s;
        s = a + b;
        return {s[M], s[M:0] == '0, a[M] == b[M] && s[M] != a[M], s[M+1]};
    endfunction
    // Byte copy result: sign-extended into a register, zero-extended towards memory.
    function automatic logic [M:0] fb(logic [M:0] s, logic r);
        return {{(M-7){r && s[7]}}, s[7:0]};
    endfunction
    // Shift step by step, so a sign flip at any intermediate step is seen.
    function automatic logic [M+2:0] fh(logic [M:0] v, logic [M:0] n);
        logic s;
        logic vf;
        logic cf;
        int k;
        s = v[M];
        vf = 1'b0;
        cf = 1'b0;
        k = $signed(n[5:0]);
        for (int i = 0; i < (k < 0 ? -k : k); i++) begin
            cf = k < 0 ? v[0] : v[M];
            v = k < 0 ? {v[M], v[M:1]} : v << 1;
            vf = vf | (v[M] != s);
        end
        return {v, vf, cf};
    endfunction
    a_done_timing: assert property (start_i |=> done_o) else $error("done late");
    a_idle_quiet: assert property (!start_i |=> !done_o && !write_o) else $error("strobe without request");
    a_compare_no_write: assert property (start_i && op_i inside {DOALU_COMPARE_OP, DOALU_BYTE_COMPARE_OP} |=>
        !write_o) else $error("compare wrote");
    a_compare_flags: assert property (start_i && op_i == DOALU_COMPARE_OP |=>
        flags_o == fs($past(src_i), $past(dst_i))) else $error("compare flags");
    a_sub_result: assert property (start_i && op_i == DOALU_SUB_OP |=> write_o && !byte_write_o &&
        result_o == $past(dst_i) - $past(src_i) &&
        flags_o == fs($past(dst_i), $past(src_i))) else $error("sub result");
    a_add_result: assert property (start_i && op_i == DOALU_ADD_OP |=> write_o && !byte_write_o &&
        result_o == $past(src_i) + $past(dst_i) &&
        flags_o == fa($past(src_i), $past(dst_i))) else $error("add result");
    a_byte_copy: assert property (start_i && op_i == DOALU_BYTE_COPY_OP |=>
        byte_write_o != $past(dst_is_reg_i) &&
        result_o == fb($past(src_i), $past(dst_is_reg_i))) else $error("byte copy");
    a_shift_result: assert property (start_i && op_i == DOALU_ARITH_SHIFT_OP |=>
        {result_o, flags_o[1:0]} == fh($past(dst_i), $past(src_i))) else $error("shift result");
    // Main scenarios: back-to-back requests, a right shift and an overflow.
    c_back_to_back: cover property (start_i [*3]);
    c_right_shift: cover property (start_i && op_i == DOALU_ARITH_SHIFT_OP && src_i[5]);
    c_overflow: cover property (done_o && flags_o[1]);
endmodule
`default_nettype wire

// ---- bench/double_operand_alu_tb.sv ----
// Self-checking bench of the double-operand datapath.
`timescale 1ns/1ps
`default_nettype none
module double_operand_alu_tb;
    import doalu_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i;
    logic start_i = 1'b0;
    logic dst_is_reg_i = 1'b0;
    doalu_op_t op_i = DOALU_WORD_COPY_OP;
    logic [15:0] src_i = 16'h0000;
    logic [15:0] dst_i = 16'h0000;
    logic done_o, write_o, byte_write_o;
    logic [15:0] result_o;
    logic [3:0] flags_o;
    logic [3:0] last_fl;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    doalu_top doalu_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i),
        .dst_is_reg_i(dst_is_reg_i), .src_i(src_i), .dst_i(dst_i), .done_o(done_o), .write_o(write_o),
        .byte_write_o(byte_write_o), .result_o(result_o), .flags_o(flags_o));
    // Clock of 4 ns.
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // A hang is cut short long after the tests should have ended.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            failures = failures + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [22:0] e, logic [22:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    // One request; x packs write, byte write and NZVC. Start stays up so calls run back to back.
    // The result is ignored when no write is expected, since a compare leaves it open.
    task automatic run(doalu_op_t op, logic r, logic [15:0] s, logic [15:0] d, logic [5:0] x, logic [15:0] res);
        op_i = op;
        dst_is_reg_i = r;
        src_i = s;
        dst_i = d;
        start_i = 1'b1;
        @(posedge clk_i);
        #1;
        last_fl = x[3:0];
        chk(op.name(), {1'b1, x, res}, {done_o, write_o, byte_write_o, flags_o, x[5] ? result_o : res});
    endtask
    // With no request the strobes drop and the flags hold.
    task automatic idle();
        start_i = 1'b0;
        @(posedge clk_i);
        #1;
        chk("idle", {3'h0, last_fl, 16'h0000}, {done_o, write_o, byte_write_o, flags_o, 16'h0000});
    endtask
    task automatic reset_dut();
        rst_b_i = 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        chk("reset", 23'h000000, {done_o, write_o, byte_write_o, flags_o, result_o});
        rst_b_i = 1'b1;
    endtask
    initial begin
        reset_dut();
        run(DOALU_ADD_OP, 1'h0, 16'h7FFF, 16'h0001, 6'h2A, 16'h8000);
        run(DOALU_ADD_OP, 1'h0, 16'hFFFF, 16'h0001, 6'h25, 16'h0000);
        run(DOALU_SUB_OP, 1'h0, 16'h1249, 16'h14E5, 6'h20, 16'h029C);
        run(DOALU_SUB_OP, 1'h0, 16'h0001, 16'h8000, 6'h22, 16'h7FFF);
        run(DOALU_SUB_OP, 1'h0, 16'h0001, 16'h0000, 6'h29, 16'hFFFF);
        run(DOALU_WORD_COPY_OP, 1'h0, 16'h8000, 16'h1234, 6'h29, 16'h8000);
        run(DOALU_BYTE_COPY_OP, 1'h1, 16'h0080, 16'h1234, 6'h29, 16'hFF80);
        run(DOALU_BYTE_COPY_OP, 1'h0, 16'hFF00, 16'h1234, 6'h35, 16'h0000);
        run(DOALU_COMPARE_OP, 1'h0, 16'h0005, 16'h0003, 6'h00, 16'h0000);
        run(DOALU_COMPARE_OP, 1'h0, 16'h0003, 16'h0005, 6'h09, 16'h0000);
        run(DOALU_COMPARE_OP, 1'h0, 16'h8000, 16'h0001, 6'h02, 16'h0000);
        run(DOALU_BYTE_COMPARE_OP, 1'h0, 16'h1280, 16'h3401, 6'h02, 16'h0000);
        run(DOALU_ARITH_SHIFT_OP, 1'h0, 16'h0001, 16'h4000, 6'h2A, 16'h8000);
        run(DOALU_ARITH_SHIFT_OP, 1'h0, 16'h003F, 16'h0003, 6'h21, 16'h0001);
        run(DOALU_ARITH_SHIFT_OP, 1'h0, 16'hFFE0, 16'h8000, 6'h29, 16'hFFFF);
        run(DOALU_ARITH_SHIFT_OP, 1'h0, 16'h001F, 16'h0001, 6'h26, 16'h0000);
        run(DOALU_ARITH_SHIFT_OP, 1'h0, 16'h0040, 16'h1234, 6'h20, 16'h1234);
        run(doalu_op_t'(3'h7), 1'h0, 16'h0001, 16'h0001, 6'h00, 16'h0000);
        idle();
        reset_dut();
        run(DOALU_ADD_OP, 1'h0, 16'h0002, 16'h0003, 6'h20, 16'h0005);
        idle();
        close_out();
    end
endmodule
bind doalu_top doalu_props #(.WIDTH(WIDTH)) doalu_props_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .op_i(op_i), .dst_is_reg_i(dst_is_reg_i), .src_i(src_i), .dst_i(dst_i), .done_o(done_o), .write_o(write_o),
    .byte_write_o(byte_write_o), .result_o(result_o), .flags_o(flags_o));
`default_nettype wire
